// ---- rpm_pkg.sv ----
// constants for the read-protect and interrupt-mask bank
package rpm_pkg;
  // memory selects seen by the bank
  localparam logic DEV_AUX = 1'b0;
  localparam logic DEV_MAIN = 1'b1;
  // table numbers of main memory upper half
  localparam logic [7:0] TBL_USER = 8'h01;
  localparam logic [7:0] TBL_LUT_A = 8'h02;
  localparam logic [7:0] TBL_LUT_B = 8'h03;
  localparam logic [7:0] TBL_CONFIG = 8'h04;
  localparam logic [7:0] TBL_VENDOR = 8'h05;
  // register offsets in the vendor table
  localparam logic [7:0] ADDR_READ_ENABLES = 8'hd2;
  localparam logic [7:0] ADDR_PW_B3 = 8'hd3;
  localparam logic [7:0] ADDR_PW_B2 = 8'hd4;
  localparam logic [7:0] ADDR_PW_B1 = 8'hd5;
  localparam logic [7:0] ADDR_PW_B0 = 8'hd6;
  localparam logic [7:0] ADDR_ALARM_MASK_LO = 8'hf8;
  localparam logic [7:0] ADDR_ALARM_MASK_M3 = 8'hf9;
  localparam logic [7:0] ADDR_WARN_MASK_LO = 8'hfa;
  localparam logic [7:0] ADDR_WARN_MASK_M3 = 8'hfb;
  // protected block bounds
  localparam logic [7:0] PW_BLK_LO = 8'hd0;
  localparam logic [7:0] PW_BLK_HI = 8'hd6;
  localparam logic [7:0] MASK_BLK_LO = 8'hf8;
  localparam logic [7:0] MASK_BLK_HI = 8'hff;
  localparam logic [7:0] TBL_BLK_LO = 8'h80;
  localparam logic [7:0] TBL_BLK_HI = 8'hc7;
  localparam logic [7:0] USER_BLK_HI = 8'hf7;
  localparam logic [7:0] LOWER_BLK_HI = 8'h7a;
  localparam logic [7:0] UPPER_HALF = 8'h80;
  localparam logic [7:0] AUX_LO_BLK_HI = 8'h7f;
  localparam logic [7:0] BLK_BOTTOM = 8'h00;
  localparam logic [7:0] BLK_TOP = 8'hff;
  // bit positions of the read-enable byte
  localparam int BIT_PW_BLK = 7;
  localparam int BIT_VMASK_BLK = 6;
  localparam int BIT_TBL_BLK = 5;
  localparam int BIT_UMASK_BLK = 4;
  localparam int BIT_USER_BLK = 3;
  localparam int BIT_LOWER_BLK = 2;
  localparam int BIT_AUX_HI_BLK = 1;
  localparam int BIT_AUX_LO_BLK = 0;
  // third-monitor bytes keep only bits 7:6
  localparam logic [7:0] M3_KEEP = 8'hc0;
  // reset values loaded by the asynchronous reset
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [31:0] RST_PW = 32'h0000_0000;
  // value returned for a blocked or unheld byte
  localparam logic [7:0] BLOCKED_FILL = 8'hff;
  localparam logic [7:0] UNHELD_FILL = 8'h00;
  localparam int NUM_FLAGS = 10;
endpackage

// ---- rpm_bank.sv ----
// read-protect enables, level-one password and interrupt mask bank
// Function
// (R01) read-enable bit 7 blocks level-one reads of vendor D0h..D6h
// (R02) bit 6 blocks level-one reads of vendor mask bytes F8h..FFh
// (R03) bit 5 blocks 80h..C7h of config and both lookup tables
// (R04) bit 4 blocks user table F8h..FFh
// (R05) bit 3 blocks user table 80h..F7h
// (R06) bit 2 blocks lower main memory 00h..7Ah
// (R07) bit 1 blocks auxiliary memory 80h..FFh
// (R08) bit 0 blocks auxiliary memory 00h..7Fh
// (R09) read-enable byte at D2h, resets to 00h
// (R10) 32-bit password at D3h..D6h, msb first, resets to zero
// (R11) alarm mask F8h: temp, supply, monitor one, monitor two hi/lo
// (R12) alarm mask F9h: third monitor hi bit 7, lo bit 6, rest reserved
// (R13) warning mask FAh: same layout as F8h for warnings
// (R14) warning mask FBh: third monitor warnings, rest reserved
// (R15) interrupt status set when any flag with its mask bit is set
// (R16) mask-set select bit chooses which mask set drives interrupt status
// (R17) select 0 uses vendor masks, select 1 uses user-table masks
// (R18) host writes 1 to enable a flag's interrupt, 0 otherwise
// (R19) protected blocks read only after matching password entered
`timescale 1ns/1ps
module rpm_bank (
  input wire logic i_clk, // 250 MHz clock
  input wire logic i_sys_rst, // async reset, active high
  input wire logic i_wr_stb, // one-cycle byte write from serial engine
  input wire logic i_rd_stb, // one-cycle byte read from serial engine
  input wire logic i_dev_sel, // 0 auxiliary memory, 1 main memory
  input wire logic [7:0] i_table, // selected upper-half table
  input wire logic [7:0] i_addr, // byte address
  input wire logic [7:0] i_wdata, // write data
  input wire logic [31:0] i_entered_pw, // password the host has entered
  input wire logic i_mask_sel, // mask-set select from config byte
  input wire logic [31:0] i_user_masks, // user-table F8h..FBh, F8h in msbs
  input wire logic [9:0] i_alarm_flags, // alarm flags, mask bit order
  input wire logic [9:0] i_warn_flags, // warning flags, mask bit order
  output logic [7:0] o_rdata, // read data, valid with o_rvalid
  output logic o_rvalid, // one-cycle read answer
  output logic o_rd_blocked, // read was refused by protection
  output logic o_rd_held, // address is held by this bank
  output logic o_masked_interrupt_status // masked interrupt status bit
);
  logic [7:0] read_enables_reg;
  logic [31:0] level_one_password_reg;
  logic [7:0] alarm_mask_lo_reg;
  logic [7:0] alarm_mask_m3_reg;
  logic [7:0] warn_mask_lo_reg;
  logic [7:0] warn_mask_m3_reg;
  logic vendor_hit;
  logic pw_match;
  logic blocked_next;
  logic [7:0] block_hit;
  logic held_next;
  logic [7:0] held_data;
  logic [9:0] alarm_en;
  logic [9:0] warn_en;
  logic masked_interrupt_status_next;

  assign vendor_hit = (i_dev_sel == rpm_pkg::DEV_MAIN) && (i_table == rpm_pkg::TBL_VENDOR)
                      && (i_addr >= rpm_pkg::UPPER_HALF);
  assign pw_match = (i_entered_pw == level_one_password_reg);

  // one guard per enable bit; the ranges never overlap inside one memory and table
  rpm_range_guard #(
    .DEV(rpm_pkg::DEV_MAIN),
    .ANY_TBL(1'b0),
    .TBL_A(rpm_pkg::TBL_VENDOR),
    .TBL_B(rpm_pkg::TBL_VENDOR),
    .TBL_C(rpm_pkg::TBL_VENDOR),
    .LO(rpm_pkg::PW_BLK_LO),
    .HI(rpm_pkg::PW_BLK_HI)
  ) pw_guard (
    .i_dev_sel(i_dev_sel),
    .i_table(i_table),
    .i_addr(i_addr),
    .o_hit(block_hit[rpm_pkg::BIT_PW_BLK]) // [R01]
  );

  rpm_range_guard #(
    .DEV(rpm_pkg::DEV_MAIN),
    .ANY_TBL(1'b0),
    .TBL_A(rpm_pkg::TBL_VENDOR),
    .TBL_B(rpm_pkg::TBL_VENDOR),
    .TBL_C(rpm_pkg::TBL_VENDOR),
    .LO(rpm_pkg::MASK_BLK_LO),
    .HI(rpm_pkg::MASK_BLK_HI)
  ) vmask_guard (
    .i_dev_sel(i_dev_sel),
    .i_table(i_table),
    .i_addr(i_addr),
    .o_hit(block_hit[rpm_pkg::BIT_VMASK_BLK]) // [R02]
  );

  rpm_range_guard #(
    .DEV(rpm_pkg::DEV_MAIN),
    .ANY_TBL(1'b0),
    .TBL_A(rpm_pkg::TBL_CONFIG),
    .TBL_B(rpm_pkg::TBL_LUT_A),
    .TBL_C(rpm_pkg::TBL_LUT_B),
    .LO(rpm_pkg::TBL_BLK_LO),
    .HI(rpm_pkg::TBL_BLK_HI)
  ) tbl_guard (
    .i_dev_sel(i_dev_sel),
    .i_table(i_table),
    .i_addr(i_addr),
    .o_hit(block_hit[rpm_pkg::BIT_TBL_BLK]) // [R03]
  );

  rpm_range_guard #(
    .DEV(rpm_pkg::DEV_MAIN),
    .ANY_TBL(1'b0),
    .TBL_A(rpm_pkg::TBL_USER),
    .TBL_B(rpm_pkg::TBL_USER),
    .TBL_C(rpm_pkg::TBL_USER),
    .LO(rpm_pkg::MASK_BLK_LO),
    .HI(rpm_pkg::MASK_BLK_HI)
  ) umask_guard (
    .i_dev_sel(i_dev_sel),
    .i_table(i_table),
    .i_addr(i_addr),
    .o_hit(block_hit[rpm_pkg::BIT_UMASK_BLK]) // [R04]
  );

  rpm_range_guard #(
    .DEV(rpm_pkg::DEV_MAIN),
    .ANY_TBL(1'b0),
    .TBL_A(rpm_pkg::TBL_USER),
    .TBL_B(rpm_pkg::TBL_USER),
    .TBL_C(rpm_pkg::TBL_USER),
    .LO(rpm_pkg::TBL_BLK_LO),
    .HI(rpm_pkg::USER_BLK_HI)
  ) user_guard (
    .i_dev_sel(i_dev_sel),
    .i_table(i_table),
    .i_addr(i_addr),
    .o_hit(block_hit[rpm_pkg::BIT_USER_BLK]) // [R05]
  );

  // lower main memory ignores the table number; 7bh..7fh are never blocked
  rpm_range_guard #(
    .DEV(rpm_pkg::DEV_MAIN),
    .ANY_TBL(1'b1),
    .TBL_A(rpm_pkg::TBL_USER),
    .TBL_B(rpm_pkg::TBL_USER),
    .TBL_C(rpm_pkg::TBL_USER),
    .LO(rpm_pkg::BLK_BOTTOM),
    .HI(rpm_pkg::LOWER_BLK_HI)
  ) lower_guard (
    .i_dev_sel(i_dev_sel),
    .i_table(i_table),
    .i_addr(i_addr),
    .o_hit(block_hit[rpm_pkg::BIT_LOWER_BLK]) // [R06]
  );

  // auxiliary memory has no tables, so the table fields are not decoded
  rpm_range_guard #(
    .DEV(rpm_pkg::DEV_AUX),
    .ANY_TBL(1'b1),
    .TBL_A(rpm_pkg::TBL_USER),
    .TBL_B(rpm_pkg::TBL_USER),
    .TBL_C(rpm_pkg::TBL_USER),
    .LO(rpm_pkg::UPPER_HALF),
    .HI(rpm_pkg::BLK_TOP)
  ) aux_hi_guard (
    .i_dev_sel(i_dev_sel),
    .i_table(i_table),
    .i_addr(i_addr),
    .o_hit(block_hit[rpm_pkg::BIT_AUX_HI_BLK]) // [R07]
  );

  rpm_range_guard #(
    .DEV(rpm_pkg::DEV_AUX),
    .ANY_TBL(1'b1),
    .TBL_A(rpm_pkg::TBL_USER),
    .TBL_B(rpm_pkg::TBL_USER),
    .TBL_C(rpm_pkg::TBL_USER),
    .LO(rpm_pkg::BLK_BOTTOM),
    .HI(rpm_pkg::AUX_LO_BLK_HI)
  ) aux_lo_guard (
    .i_dev_sel(i_dev_sel),
    .i_table(i_table),
    .i_addr(i_addr),
    .o_hit(block_hit[rpm_pkg::BIT_AUX_LO_BLK]) // [R08]
  );

  // a matching password lifts every block at once
  always_comb
  begin
    blocked_next = |(block_hit & read_enables_reg);
    if (pw_match)
      blocked_next = 1'b0; // [R19]
  end

  // bytes this bank holds itself; others are answered by the memory outside
  always_comb
  begin
    held_next = vendor_hit;
    held_data = rpm_pkg::UNHELD_FILL;
    if (vendor_hit)
    begin
      case (i_addr)
        rpm_pkg::ADDR_READ_ENABLES: held_data = read_enables_reg;
        rpm_pkg::ADDR_PW_B3: held_data = level_one_password_reg[31:24];
        rpm_pkg::ADDR_PW_B2: held_data = level_one_password_reg[23:16];
        rpm_pkg::ADDR_PW_B1: held_data = level_one_password_reg[15:8];
        rpm_pkg::ADDR_PW_B0: held_data = level_one_password_reg[7:0];
        rpm_pkg::ADDR_ALARM_MASK_LO: held_data = alarm_mask_lo_reg;
        rpm_pkg::ADDR_ALARM_MASK_M3: held_data = alarm_mask_m3_reg;
        rpm_pkg::ADDR_WARN_MASK_LO: held_data = warn_mask_lo_reg;
        rpm_pkg::ADDR_WARN_MASK_M3: held_data = warn_mask_m3_reg;
        default:
        begin
          held_next = 1'b0;
          held_data = rpm_pkg::UNHELD_FILL;
        end
      endcase
    end
  end

  // register writes; write protection is enforced by the serial engine
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      read_enables_reg <= rpm_pkg::RST_BYTE; // [R09]
    else if (i_wr_stb && vendor_hit && i_addr == rpm_pkg::ADDR_READ_ENABLES)
      read_enables_reg <= i_wdata; // [R09]
  end

  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      level_one_password_reg <= rpm_pkg::RST_PW; // [R10]
    else if (i_wr_stb && vendor_hit)
    begin
      case (i_addr)
        rpm_pkg::ADDR_PW_B3: level_one_password_reg[31:24] <= i_wdata; // [R10]
        rpm_pkg::ADDR_PW_B2: level_one_password_reg[23:16] <= i_wdata; // [R10]
        rpm_pkg::ADDR_PW_B1: level_one_password_reg[15:8] <= i_wdata; // [R10]
        rpm_pkg::ADDR_PW_B0: level_one_password_reg[7:0] <= i_wdata; // [R10]
        default: level_one_password_reg <= level_one_password_reg;
      endcase
    end
  end

  // reserved mask bits are not stored so they always read zero
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      alarm_mask_lo_reg <= rpm_pkg::RST_BYTE;
      alarm_mask_m3_reg <= rpm_pkg::RST_BYTE;
      warn_mask_lo_reg <= rpm_pkg::RST_BYTE;
      warn_mask_m3_reg <= rpm_pkg::RST_BYTE;
    end
    else if (i_wr_stb && vendor_hit)
    begin
      case (i_addr)
        rpm_pkg::ADDR_ALARM_MASK_LO: alarm_mask_lo_reg <= i_wdata; // [R11]
        rpm_pkg::ADDR_ALARM_MASK_M3: alarm_mask_m3_reg <= i_wdata & rpm_pkg::M3_KEEP; // [R12]
        rpm_pkg::ADDR_WARN_MASK_LO: warn_mask_lo_reg <= i_wdata; // [R13]
        rpm_pkg::ADDR_WARN_MASK_M3: warn_mask_m3_reg <= i_wdata & rpm_pkg::M3_KEEP; // [R14]
        default: alarm_mask_lo_reg <= alarm_mask_lo_reg;
      endcase
    end
  end

  // read answer one cycle after the strobe
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      o_rdata <= rpm_pkg::UNHELD_FILL;
      o_rvalid <= 1'b0;
      o_rd_blocked <= 1'b0;
      o_rd_held <= 1'b0;
    end
    else
    begin
      o_rvalid <= i_rd_stb;
      if (i_rd_stb)
      begin
        o_rd_blocked <= blocked_next; // [R19]
        o_rd_held <= held_next;
        o_rdata <= blocked_next ? rpm_pkg::BLOCKED_FILL : held_data; // [R19]
      end
    end
  end

  // user-table masks arrive in the same layout as the vendor bytes
  always_comb
  begin
    if (i_mask_sel) // [R16]
    begin
      alarm_en = {i_user_masks[31:24], i_user_masks[23:22]}; // [R17]
      warn_en = {i_user_masks[15:8], i_user_masks[7:6]}; // [R17]
    end
    else
    begin
      alarm_en = {alarm_mask_lo_reg, alarm_mask_m3_reg[7:6]}; // [R17]
      warn_en = {warn_mask_lo_reg, warn_mask_m3_reg[7:6]}; // [R17]
    end
    masked_interrupt_status_next = |(i_alarm_flags & alarm_en) | |(i_warn_flags & warn_en); // [R15]
  end

  // level follows the flags; clearing is up to whoever clears the flags
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      o_masked_interrupt_status <= 1'b0;
    else
      o_masked_interrupt_status <= masked_interrupt_status_next; // [R15]
  end
endmodule

// one protected address block: memory, table set and inclusive address range
module rpm_range_guard #(
  parameter logic DEV = 1'b1, // memory holding the block
  parameter logic ANY_TBL = 1'b0, // table number not decoded
  parameter logic [7:0] TBL_A = 8'h00, // first table of the block
  parameter logic [7:0] TBL_B = 8'h00, // second table of the block
  parameter logic [7:0] TBL_C = 8'h00, // third table of the block
  parameter logic [7:0] LO = 8'h00, // first address of the block
  parameter logic [7:0] HI = 8'hff // last address of the block
) (
  input wire logic i_dev_sel, // memory select
  input wire logic [7:0] i_table, // table number
  input wire logic [7:0] i_addr, // byte address
  output logic o_hit // request falls in the block
);
  logic dev_ok;
  logic tbl_match;
  logic tbl_ok;
  logic addr_ok;

  assign dev_ok = (i_dev_sel == DEV);
  // repeating a table in the set costs nothing and keeps one guard shape for all blocks
  assign tbl_match = (i_table == TBL_A) || (i_table == TBL_B) || (i_table == TBL_C);
  assign tbl_ok = ANY_TBL || tbl_match;
  assign addr_ok = (i_addr >= LO) && (i_addr <= HI);
  assign o_hit = dev_ok && tbl_ok && addr_ok;
endmodule

// ---- rpm_bank_assertions.sv ----
// port checker for the read-protect and mask bank
`timescale 1ns/1ps
module rpm_bank_checker (
  input wire logic i_clk, // clock
  input wire logic i_sys_rst, // reset
  input wire logic i_wr_stb, // write
  input wire logic i_rd_stb, // read
  input wire logic i_dev_sel, // memory
  input wire logic [7:0] i_table, // table
  input wire logic [7:0] i_addr, // address
  input wire logic [7:0] i_wdata, // data
  input wire logic [31:0] i_entered_pw, // password
  input wire logic i_mask_sel, // mask set
  input wire logic [31:0] i_user_masks, // user masks
  input wire logic [9:0] i_alarm_flags, // alarms
  input wire logic [9:0] i_warn_flags, // warnings
  input wire logic [7:0] o_rdata, // read data
  input wire logic o_rvalid, // answer
  input wire logic o_rd_blocked, // refused
  input wire logic o_rd_held, // held
  input wire logic o_masked_interrupt_status // interrupt
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_sys_rst);
  sequence f8_write;
    i_wr_stb && i_dev_sel && i_table == 8'h05 && i_addr == 8'hf8;
  endsequence
  sequence f8_read;
    i_rd_stb && i_dev_sel && i_table == 8'h05 && i_addr == 8'hf8;
  endsequence
  read_answered_a: assert property (i_rd_stb |=> o_rvalid)
    else $error("read not answered");
  no_stray_answer_a: assert property (!i_rd_stb |=> !o_rvalid)
    else $error("answer without read");
  blocked_fill_a: assert property (o_rvalid && o_rd_blocked |-> o_rdata == 8'hff)
    else $error("blocked read leaked data");
  unheld_fill_a: assert property (o_rvalid && !o_rd_held && !o_rd_blocked |-> o_rdata == 8'h00)
    else $error("unheld read not zero");
  status_stands_a: assert property (!i_rd_stb |=> $stable(o_rd_blocked) && $stable(o_rdata))
    else $error("read result changed without read");
  mask_readback_a: assert property (f8_write ##2 f8_read |=> o_rd_blocked || o_rdata == $past(i_wdata, 3))
    else $error("alarm mask readback wrong");
  intr_quiet_a: assert property (i_alarm_flags == 10'h000 && i_warn_flags == 10'h000 |=> !o_masked_interrupt_status)
    else $error("interrupt without flags");
  user_set_a: assert property (i_mask_sel && (i_alarm_flags & {i_user_masks[31:24], i_user_masks[23:22]}) != 10'h000 |=> o_masked_interrupt_status)
    else $error("user mask set ignored");
endmodule
bind rpm_bank rpm_bank_checker chk (.i_clk, .i_sys_rst, .i_wr_stb, .i_rd_stb, .i_dev_sel,
  .i_table, .i_addr, .i_wdata, .i_entered_pw, .i_mask_sel, .i_user_masks, .i_alarm_flags,
  .i_warn_flags, .o_rdata, .o_rvalid, .o_rd_blocked, .o_rd_held, .o_masked_interrupt_status);

// ---- rpm_host.sv ----
// host model issuing one-byte requests to the bank
`timescale 1ns/1ps
module rpm_host (
  input wire logic i_clk, // clock
  output logic o_wr_stb, // write pulse
  output logic o_rd_stb, // read pulse
  output logic o_dev_sel, // memory select
  output logic [7:0] o_table, // table number
  output logic [7:0] o_addr, // byte address
  output logic [7:0] o_wdata // write data
);
  initial {o_wr_stb, o_rd_stb, o_dev_sel, o_table, o_addr, o_wdata} = '0;
  // fields are scrambled once released so a stale value never helps the bank
  task automatic access(input logic w, d, input logic [7:0] t, a, v);
    @(posedge i_clk);
    #1 {o_wr_stb, o_rd_stb, o_dev_sel, o_table, o_addr, o_wdata} = {w, !w, d, t, a, v};
    @(posedge i_clk);
    #1 {o_wr_stb, o_rd_stb, o_dev_sel, o_table, o_addr, o_wdata} = {2'b00, ~d, ~t, ~a, ~v};
  endtask
endmodule

// ---- tb_top.sv ----
// self-checking bench for the read-protect and mask bank
`timescale 1ns/1ps
module tb_top;
  logic i_clk = 0, i_sys_rst = 1, i_mask_sel = 0, x;
  logic i_wr_stb, i_rd_stb, i_dev_sel, o_rvalid, o_rd_blocked, o_rd_held;
  logic o_masked_interrupt_status;
  logic [7:0] i_table, i_addr, i_wdata, o_rdata, en = 0;
  logic [7:0] mk [4] = '{default: 8'h00};
  logic [31:0] i_entered_pw = 0, i_user_masks = 0, pw = 0, m;
  logic [9:0] i_alarm_flags = 0, i_warn_flags = 0;
  int fail_count = 0, checks = 0, seed = 79262;
  logic [7:0] regs [9] = '{8'hd2, 8'hd3, 8'hd4, 8'hd5, 8'hd6, 8'hf8, 8'hf9, 8'hfa, 8'hfb};
  logic [7:0] b_in [8] = '{8'h7f, 8'hff, 8'h7a, 8'hf7, 8'hff, 8'hc7, 8'hff, 8'hd6};
  logic [7:0] b_out [8] = '{8'h80, 8'h7f, 8'h7b, 8'hf8, 8'hf7, 8'hc8, 8'hf7, 8'hd7};
  logic [7:0] b_tbl [8] = '{8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h04, 8'h05, 8'h05};
  initial forever #2 i_clk = ~i_clk;
  rpm_host host (.i_clk, .o_wr_stb(i_wr_stb), .o_rd_stb(i_rd_stb), .o_dev_sel(i_dev_sel),
    .o_table(i_table), .o_addr(i_addr), .o_wdata(i_wdata));
  rpm_bank dut (.i_clk, .i_sys_rst, .i_wr_stb, .i_rd_stb, .i_dev_sel, .i_table, .i_addr,
    .i_wdata, .i_entered_pw, .i_mask_sel, .i_user_masks, .i_alarm_flags, .i_warn_flags,
    .o_rdata, .o_rvalid, .o_rd_blocked, .o_rd_held, .o_masked_interrupt_status);
  // model view of a byte: held flag over data, only vendor bytes live here
  function automatic logic [8:0] ev(logic d, logic [7:0] t, logic [7:0] a);
    if (!d || t != 8'h05) return 9'h000;
    case (a)
      8'hd2: return {1'b1, en};
      8'hd3, 8'hd4, 8'hd5, 8'hd6: return {1'b1, 8'(pw >> (8 * (8'hd6 - a)))};
      8'hf8, 8'hf9, 8'hfa, 8'hfb: return {1'b1, mk[a - 8'hf8]};
      default: return 9'h000;
    endcase
  endfunction
  task chk(input string n, input logic [31:0] e, input logic [31:0] s);
    checks++;
    if (s !== e)
    begin
      fail_count++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task rd(input logic d, input logic [7:0] t, input logic [7:0] a, input logic b);
    logic [8:0] e;
    e = ev(d, t, a);
    host.access(1'b0, d, t, a, 8'h00);
    chk("rvalid", 1, o_rvalid);
    chk("blocked", b, o_rd_blocked);
    chk("rdata", b ? 8'hff : e[7:0], o_rdata);
    if (!b) chk("held", e[8], o_rd_held);
  endtask
  task wr(input logic [7:0] a, input logic [7:0] v);
    host.access(1'b1, 1'b1, 8'h05, a, v);
    if (a == 8'hd2) en = v;
    else if (a < 8'hf8) pw[8 * (8'hd6 - a) +: 8] = v;
    else mk[a - 8'hf8] = a[0] ? (v & 8'hc0) : v;
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    #40000;
    fail_count++;
    wrap_up();
  end
  initial
  begin
    repeat (20) @(posedge i_clk);
    #1 i_sys_rst = 0;
    for (int i = 0; i < 9; i++) rd(1'b1, 8'h05, regs[i], 1'b0);
    $display("reset values done");
    for (int i = 1; i < 9; i++)
    begin
      wr(regs[i], 8'($random(seed)));
      rd(1'b1, 8'h05, regs[i], 1'b0);
    end
    $display("readback done");
    i_entered_pw = ~pw;
    for (int b = 0; b < 8; b++)
    begin
      wr(8'hd2, 8'h01 << b);
      rd(b > 1, b_tbl[b], b_in[b], 1'b1);
      rd(b > 1, b_tbl[b], b_out[b], 1'b0);
      i_entered_pw = pw;
      rd(b > 1, b_tbl[b], b_in[b], 1'b0);
      i_entered_pw = ~pw;
    end
    wr(8'hd2, 8'h00);
    $display("protection done");
    for (int n = 0; n < 24; n++)
    begin
      i_alarm_flags = 10'($random(seed) & $random(seed));
      i_warn_flags = n[0] ? 10'h000 : 10'($random(seed) & $random(seed));
      i_user_masks = $random(seed);
      i_mask_sel = n[1];
      m = i_mask_sel ? i_user_masks : {mk[0], mk[1], mk[2], mk[3]};
      x = |(i_alarm_flags & {m[31:24], m[23:22]}) | |(i_warn_flags & {m[15:8], m[7:6]});
      repeat (2) @(posedge i_clk);
      #1 chk("interrupt", x, o_masked_interrupt_status);
    end
    $display("interrupt done");
    wrap_up();
  end
endmodule
